// ===== cell_monitor_irq.sv
// event flags, interrupt mask, interrupt pulse and cell tap selection
//
// What this block does
// - mask bit 4 stops over-temperature pulses; its flag still sets.
// - mask bit 3 stops second wake pulses; its flag still sets.
// - mask bit 2 stops first wake pulses; its flag still sets.
// - mask bit 0 stops short-current pulses; its flag still sets.
// - flag bit 4 sets on over-temperature status rising edge.
// - flag bit 3 sets on second wake status rising edge.
// - flag bit 2 sets on first wake status rising edge.
// - flag bit 0 sets on short-current status rising edge.
// - completed read of flag register clears all flags except one whose edge lands in that cycle; flags read-only.
// - mask and flag registers reset to all zero.
// - scan disabled opens all tap switches, output zero.
// - scan enabled closes only the switch at bit select.
// - statuses sit at status bits 4, 3, 2 and 0.
// - host write of first wake status is not seen; only chip_status edges set flags.
`include "cell_monitor_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_irq
  import cell_monitor_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic [7:0]                   chip_status,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read_done,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire cell_monitor_pkg::cell_sel_s  cell_sel,
  output logic [7:0]                        irq_mask_rdata,
  output logic [7:0]                        irq_flags_rdata,
  output logic                              irq_out_n,
  output logic [7:0]                        cell_tap_switches,
  output logic                              scaled_output_active
);
  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

  // status arrives from analogue detectors, asynchronous to clk
  logic [7:0]    stat_meta_q;
  logic [7:0]    stat_meta_d;
  logic [7:0]    stat_sync_q;
  logic [7:0]    stat_sync_d;
  logic [7:0]    stat_prev_q;
  logic [7:0]    stat_prev_d;

  // mask reserved bits are never stored, so they always read back zero
  logic [7:0]    mask_q;
  logic [7:0]    mask_d;
  logic [7:0]    flags_q;
  logic [7:0]    flags_d;

  // one counter serves all four sources; separate pulses per source buy nothing on one pin
  logic [CW-1:0] pulse_cnt_q;
  logic [CW-1:0] pulse_cnt_d;
  logic          irq_n_q;
  logic          irq_n_d;

  logic [7:0]    rise;
  logic [7:0]    unmasked_rise;
  reg_access_e   acc;

  // field placement is shared by the edge path, so it lives in functions
  function automatic event_set_s pick_events(input logic [7:0] v);
    event_set_s e;
    e.overtemp      = v[`BIT_OVERTEMP];
    e.wake_two      = v[`BIT_WAKE_TWO];
    e.wake_one      = v[`BIT_WAKE_ONE];
    e.short_current = v[`BIT_SHORT_CURRENT];
    return e;
  endfunction

  function automatic logic [7:0] place_events(input event_set_s e);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_OVERTEMP]      = e.overtemp;
    v[`BIT_WAKE_TWO]      = e.wake_two;
    v[`BIT_WAKE_ONE]      = e.wake_one;
    v[`BIT_SHORT_CURRENT] = e.short_current;
    return v;
  endfunction

  // a write wins over a read strobe in the same cycle
  always_comb begin
    acc = ACC_NONE;
    if (reg_write) begin
      acc = ACC_WRITE;
    end else if (reg_read_done && reg_addr == `REG_IRQ_FLAGS) begin
      acc = ACC_READ_DONE;
    end
  end

  // only the second stage reads the first, so a metastable value never reaches logic
  always_comb begin
    stat_meta_d = chip_status;
    stat_sync_d = stat_meta_q;
    stat_prev_d = stat_sync_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_meta_q <= 8'h00;
      stat_sync_q <= 8'h00;
      stat_prev_q <= 8'h00;
    end else begin
      stat_meta_q <= stat_meta_d;
      stat_sync_q <= stat_sync_d;
      stat_prev_q <= stat_prev_d;
    end
  end

  // a status level shorter than about one clock may be missed by the edge compare
  always_comb begin
    // a host write to first wake status never reaches chip_status, so it is not seen here
    rise          = place_events(pick_events(stat_sync_q & ~stat_prev_q));
    unmasked_rise = rise & ~mask_q;
  end

  // the mask gates only the pin; flags set whatever it holds
  always_comb begin
    mask_d = mask_q;
    case (acc)
      ACC_WRITE: begin
        if (reg_addr == `REG_IRQ_MASK) begin
          // reserved bits are held at zero whatever the host sends
          mask_d = reg_wdata & `EVENT_BITS_MASK;
        end
      end
      default: begin
        mask_d = mask_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= `IRQ_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // flags are read-only; a host write to their address falls through to default
  always_comb begin
    flags_d = flags_q;
    case (acc)
      ACC_READ_DONE: begin
        flags_d = 8'h00;
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
    // set wins over the read-clear, so an edge in that very cycle is kept
    flags_d = flags_d | rise;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= `IRQ_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    if (|unmasked_rise) begin
      // a new entry during a pulse restarts it, so coincident events share one
      pulse_cnt_d = CW'(PULSE_CYCLES);
    end else if (pulse_cnt_q != '0) begin
      // count down and rest at zero, which means the pin is idle
      pulse_cnt_d = pulse_cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_q <= '0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // the pin follows the next count, so it falls in the same cycle as the flag
  always_comb begin
    irq_n_d = 1'b1;
    if (pulse_cnt_d != '0) begin
      irq_n_d = 1'b0;
    end
  end

  // idle high from reset, so power-up gives no false interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= irq_n_d;
    end
  end

  assign irq_mask_rdata  = mask_q;
  assign irq_flags_rdata = flags_q;
  assign irq_out_n       = irq_n_q;

  // the tap decoder registers its own outputs so they also leave from flops
  cell_tap_decoder u_tap (
    .clk                  (clk),
    .arst_n               (arst_n),
    .sel                  (cell_sel),
    .cell_tap_switches    (cell_tap_switches),
    .scaled_output_active (scaled_output_active)
  );
endmodule // cell_monitor_irq
`default_nettype wire

// ===== cell_monitor_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CELL_MONITOR_REGS_SVH
`define CELL_MONITOR_REGS_SVH
`define REG_CHIP_STATUS      8'h07
`define REG_IRQ_MASK         8'h08
`define REG_IRQ_FLAGS        8'h09
`define BIT_OVERTEMP         4
`define BIT_WAKE_TWO         3
`define BIT_WAKE_ONE         2
`define BIT_SHORT_CURRENT    0
`define EVENT_BITS_MASK      8'h1D
`define IRQ_MASK_RESET       8'h00
`define IRQ_FLAGS_RESET      8'h00
`define IRQ_PULSE_NS         1000
`define CLK_PERIOD_NS        8
`define IRQ_PULSE_CYCLES     ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== cell_monitor_pkg.sv
// types shared by the interrupt and cell select logic
package cell_monitor_pkg;
  typedef struct packed {
    logic overtemp;
    logic wake_two;
    logic wake_one;
    logic short_current;
  } event_set_s;
  typedef struct packed {
    logic       scan_enable;
    logic [2:0] cell_select;
  } cell_sel_s;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_READ_DONE
  } reg_access_e;
endpackage

// ===== cell_tap_decoder.sv
// one-hot decoder from cell select to the eight tap switches
`timescale 1ns/1ps
`default_nettype none
module cell_tap_decoder
  import cell_monitor_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire cell_monitor_pkg::cell_sel_s sel,
  output logic [7:0]                     cell_tap_switches,
  output logic                           scaled_output_active
);
  logic [7:0] sw_d;
  logic [7:0] sw_q;
  logic       act_d;
  logic       act_q;

  always_comb begin
    sw_d  = 8'h00;
    act_d = 1'b0;
    if (sel.scan_enable) begin
      sw_d  = 8'h01 << sel.cell_select;
      act_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_q  <= 8'h00;
      act_q <= 1'b0;
    end else begin
      sw_q  <= sw_d;
      act_q <= act_d;
    end
  end

  assign cell_tap_switches    = sw_q;
  assign scaled_output_active = act_q;
endmodule // cell_tap_decoder
`default_nettype wire

// ===== cell_monitor_irq_asserts.sv
// port assertions for cell_monitor_irq
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_irq_asserts
  import cell_monitor_pkg::*;
#(parameter int unsigned PULSE_CYCLES = 125) (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic [7:0]                 chip_status,
  input wire logic                       reg_write,
  input wire logic                       reg_read_done,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire cell_monitor_pkg::cell_sel_s cell_sel,
  input wire logic [7:0]                 irq_mask_rdata,
  input wire logic [7:0]                 irq_flags_rdata,
  input wire logic                       irq_out_n,
  input wire logic [7:0]                 cell_tap_switches,
  input wire logic                       scaled_output_active
);
  logic [7:0] low_q;
  logic [7:0] low_d;
  // a restart only lengthens a pulse, so only the lower bound is safe
  always_comb low_d = irq_out_n ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) low_q <= 8'h00;
    else low_q <= low_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ot_flag_set:
    assert property ($rose(chip_status[4]) |-> ##3 irq_flags_rdata[4]) else $error("ot flag");
  chk_w2_flag_set:
    assert property ($rose(chip_status[3]) |-> ##3 irq_flags_rdata[3]) else $error("w2 flag");
  chk_w1_flag_set:
    assert property ($rose(chip_status[2]) |-> ##3 irq_flags_rdata[2]) else $error("w1 flag");
  chk_sc_flag_set:
    assert property ($rose(chip_status[0]) |-> ##3 irq_flags_rdata[0]) else $error("sc flag");
  chk_read_clears_flags:
    assert property (reg_read_done && !reg_write && reg_addr == 8'h09 && $stable(chip_status)
      && chip_status == $past(chip_status, 2) && chip_status == $past(chip_status, 3)
      |=> irq_flags_rdata == 8'h00) else $error("flags not cleared");
  chk_mask_write_bits:
    assert property (reg_write && reg_addr == 8'h08 |=> irq_mask_rdata == ($past(reg_wdata) & 8'h1D))
      else $error("mask write");
  chk_pulse_has_cause:
    assert property ($fell(irq_out_n) |-> ($past(chip_status, 3) & ~$past(chip_status, 4)
      & ~$past(irq_mask_rdata) & 8'h1D) != 8'h00) else $error("pulse without unmasked edge");
  chk_pulse_min_len:
    assert property ($rose(irq_out_n) |-> low_q >= PULSE_CYCLES) else $error("pulse short");
  chk_tap_one_hot:
    assert property (1'b1 |=> cell_tap_switches == ($past(cell_sel.scan_enable)
      ? 8'h01 << $past(cell_sel.cell_select) : 8'h00)
      && scaled_output_active == $past(cell_sel.scan_enable)) else $error("tap decode");
endmodule // cell_monitor_irq_asserts
bind cell_monitor_irq cell_monitor_irq_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk, .arst_n, .chip_status, .reg_write, .reg_read_done, .reg_addr, .reg_wdata, .cell_sel,
  .irq_mask_rdata, .irq_flags_rdata, .irq_out_n, .cell_tap_switches, .scaled_output_active);
`default_nettype wire

// ===== host_model.sv
// host side register strobes of the companion die
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] irq_mask_rdata,
  input  wire logic [7:0] irq_flags_rdata,
  output logic            reg_write,
  output logic            reg_read_done,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial {reg_write, reg_read_done, reg_addr, reg_wdata} = 18'h00000;
  // caller keeps reserved mask bits 7..5 and 1 at zero
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    {reg_write, reg_wdata} <= {1'b0, ~d};
  endtask
  // data is taken first; the strobe marks the read as complete
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    d = (a == 8'h08) ? irq_mask_rdata : irq_flags_rdata;
    {reg_read_done, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_read_done <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for event flags, interrupt pulse and tap decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cell_monitor_pkg::*;
  localparam int unsigned PW = 4;
  logic       clk, arst_n, reg_write, reg_read_done, irq_out_n, scaled_output_active;
  logic [7:0] chip_status, reg_addr, reg_wdata, irq_mask_rdata, irq_flags_rdata;
  logic [7:0] cell_tap_switches, v;
  cell_sel_s  cell_sel;
  int         num_errors, checks_done, lows, b;
  cell_monitor_irq #(.PULSE_CYCLES(PW)) dut (.clk, .arst_n, .chip_status, .reg_write,
    .reg_read_done, .reg_addr, .reg_wdata, .cell_sel, .irq_mask_rdata, .irq_flags_rdata,
    .irq_out_n, .cell_tap_switches, .scaled_output_active);
  host_model host (.clk, .irq_mask_rdata, .irq_flags_rdata, .reg_write, .reg_read_done,
    .reg_addr, .reg_wdata);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  task automatic test_reset;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("reset", 8'h00, irq_mask_rdata | irq_flags_rdata | cell_tap_switches);
    chk("reset irq", 8'h01, {7'h00, irq_out_n});
    chk("reset act", 8'h00, {7'h00, scaled_output_active});
    $display("reset done");
  endtask
  // each source once unmasked, then once masked
  task automatic test_events;
    for (int i = 0; i < 8; i++) begin
      b = (i % 4 == 3) ? 0 : 4 - i % 4;
      host.write(8'h08, i < 4 ? 8'h00 : 8'(1 << b));
      chip_status[b] <= 1'b1;
      lows = 0;
      repeat (12) @(negedge clk) lows += (irq_out_n === 1'b0);
      chk("pulse", i < 4 ? 8'(PW) : 8'h00, 8'(lows));
      host.read(8'h09, v);
      chk("flag", 8'(1 << b), v);
      @(negedge clk);
      chk("clear", 8'h00, irq_flags_rdata);
      @(posedge clk);
      chip_status[b] <= 1'b0;
    end
    $display("events done");
  endtask
  task automatic test_registers;
    @(posedge clk);
    chip_status[0] <= 1'b1;
    @(posedge clk);
    host.read(8'h09, v);
    @(negedge clk);
    chk("race", 8'h01, irq_flags_rdata);
    host.write(8'h08, 8'h1D);
    @(negedge clk);
    chk("mask", 8'h1D, irq_mask_rdata);
    host.write(8'h09, 8'h1D);
    @(negedge clk);
    chk("ro", 8'h01, irq_flags_rdata);
    host.read(8'h08, v);
    @(negedge clk);
    chk("mask read", 8'h1D, v);
    chk("no clear", 8'h01, irq_flags_rdata);
    $display("registers done");
  endtask
  task automatic test_decode;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      cell_sel <= cell_sel_s'(i[3:0]);
      repeat (2) @(negedge clk);
      chk("tap", i[3] ? 8'(1 << i[2:0]) : 8'h00, cell_tap_switches);
      chk("act", 8'(i[3]), 8'(scaled_output_active));
    end
    @(posedge clk);
    cell_sel <= 4'h0;
    repeat (2) @(negedge clk);
    chk("tap off", 8'h00, cell_tap_switches);
    $display("decode done");
  endtask
  initial begin
    {arst_n, chip_status, cell_sel} = 13'h0000;
    test_reset;
    test_events;
    test_registers;
    test_decode;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
